// >>> pkg/fwg_defs.svh
/*
 Constants for the flash write and erase gate: register addresses, field
 positions, reset values, key codes and lock state codes.
 Assumes it is included by its bare name wherever these are needed.
*/
`ifndef FWG_DEFS_SVH
`define FWG_DEFS_SVH

`define FWG_CTRL_ADDR    8'h8f
`define FWG_KEY_ADDR     8'hb7
`define FWG_WE_BIT       0
`define FWG_EE_BIT       1
`define FWG_CTRL_RESET   2'h0
`define FWG_KEY_FIRST    8'ha5
`define FWG_KEY_SECOND   8'hf1
`define FWG_ST_LOCKED    2'h0
`define FWG_ST_FIRST     2'h1
`define FWG_ST_OPEN      2'h2
`define FWG_ST_DEAD      2'h3

`endif

// >>> pkg/fwg_pkg.sv
/*
 Types for the flash write and erase gate.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none
package fwg_pkg;
  typedef enum logic [1:0] {
    FWG_LOCKED = 2'b00,
    FWG_FIRST  = 2'b01,
    FWG_OPEN   = 2'b10,
    FWG_DEAD   = 2'b11
  } fwg_lock_type;

  typedef struct packed {
    logic         write_en;
    logic         erase_en;
    fwg_lock_type lock;
    logic [7:0]   rdata;
    logic         prog;
    logic         erase;
    logic [15:0]  addr;
    logic [7:0]   data;
    logic         blocked;
  } fwg_state_type;
endpackage
`default_nettype wire

// >>> hdl/fwg_gate.sv
/*
 Flash write and erase gate: control register, unlock key state machine
 and the steering of external data move writes into flash.
 Assumes the CPU issues one register or data move write per strobe, and
 that the flash array raises flash_done once per started operation.
*/
`timescale 1ns/1ps
`include "fwg_defs.svh"
`default_nettype none
module fwg_gate #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  input  wire logic              xdata_wr,
  input  wire logic [ADDR_W-1:0] xdata_addr,
  input  wire logic [7:0]        xdata_wdata,
  input  wire logic              flash_done,
  output logic                   flash_prog,
  output logic                   flash_erase,
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [7:0]        flash_data,
  output logic                   flash_blocked,
  output logic                   flash_route
);

  // The latched address is 16 bits wide; wider moves would be cut
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
    $error("fwg_gate: ADDR_W must be 1 to 16");
  end

  // ==========================================================
  // State
  fwg_pkg::fwg_state_type st_r;
  fwg_pkg::fwg_state_type st_nxt;
  logic                   busy;
  logic                   ctrl_wr;
  logic                   key_wr;
  logic                   flash_wr;
  logic                   ctrl_rd;
  logic                   key_rd;

  // One decode shared by the write and the read paths
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    return addr == target;
  endfunction

  assign busy     = st_r.prog | st_r.erase;
  assign ctrl_wr  = sfr_wr && reg_hit(sfr_addr, `FWG_CTRL_ADDR);
  assign key_wr   = sfr_wr && reg_hit(sfr_addr, `FWG_KEY_ADDR);
  assign ctrl_rd  = sfr_rd && reg_hit(sfr_addr, `FWG_CTRL_ADDR);
  assign key_rd   = sfr_rd && reg_hit(sfr_addr, `FWG_KEY_ADDR);
  // Data moves only reach flash while write enable is set
  assign flash_wr = xdata_wr && st_r.write_en;

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    if (ctrl_wr) begin
      st_nxt.write_en = sfr_wdata[`FWG_WE_BIT];
      st_nxt.erase_en = sfr_wdata[`FWG_EE_BIT];
    end
    if (key_wr) begin
      case (st_r.lock)
        fwg_pkg::FWG_LOCKED: begin
          // Any non-first key locks until reset, also on purpose
          st_nxt.lock = (sfr_wdata == `FWG_KEY_FIRST) ?
                        fwg_pkg::FWG_FIRST : fwg_pkg::FWG_DEAD;
        end
        fwg_pkg::FWG_FIRST: begin
          st_nxt.lock = (sfr_wdata == `FWG_KEY_SECOND) ?
                        fwg_pkg::FWG_OPEN : fwg_pkg::FWG_DEAD;
        end
        fwg_pkg::FWG_OPEN: st_nxt.lock = fwg_pkg::FWG_DEAD;
        fwg_pkg::FWG_DEAD: st_nxt.lock = fwg_pkg::FWG_DEAD;
        default:           st_nxt.lock = fwg_pkg::FWG_DEAD;
      endcase
    end
    if (busy && flash_done) begin
      st_nxt.prog  = 1'b0;
      st_nxt.erase = 1'b0;
      // Back to locked, not dead, so a new key pair works
      if (st_nxt.lock == fwg_pkg::FWG_OPEN) begin
        st_nxt.lock = fwg_pkg::FWG_LOCKED;
      end
    end
    st_nxt.blocked = 1'b0;
    if (flash_wr && !key_wr) begin
      if (st_r.lock == fwg_pkg::FWG_OPEN && !busy) begin
        st_nxt.erase = st_r.erase_en;
        st_nxt.prog  = !st_r.erase_en;
        // Page erase ignores the data byte
        st_nxt.data  = st_r.erase_en ? 8'hff : xdata_wdata;
        st_nxt.addr  = 16'(xdata_addr);
        // Opening is spent by this one operation
        st_nxt.lock  = fwg_pkg::FWG_OPEN;
      end else begin
        st_nxt.blocked = 1'b1;
        st_nxt.lock    = fwg_pkg::FWG_DEAD;
      end
    end
    st_nxt.rdata = 8'h00;
    if (ctrl_rd) begin
      st_nxt.rdata = {6'h00, st_nxt.erase_en, st_nxt.write_en};
    end else if (key_rd) begin
      st_nxt.rdata = {6'h00, st_nxt.lock};
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata     = st_r.rdata;
  assign flash_prog    = st_r.prog;
  assign flash_erase   = st_r.erase;
  assign flash_addr    = st_r.addr[ADDR_W-1:0];
  assign flash_data    = st_r.data;
  assign flash_blocked = st_r.blocked;
  // Route follows the write enable flip-flop directly
  assign flash_route   = st_r.write_en;

  // ==========================================================
  // Checks
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Key sequence checks
  a_first_key: assert property (
    key_wr && st_r.lock == fwg_pkg::FWG_LOCKED && !flash_wr &&
    sfr_wdata == `FWG_KEY_FIRST |=> st_r.lock == fwg_pkg::FWG_FIRST)
    else $error("first key not taken");
  a_key_open: assert property (
    key_wr && st_r.lock == fwg_pkg::FWG_FIRST &&
    sfr_wdata == `FWG_KEY_SECOND |=> st_r.lock == fwg_pkg::FWG_OPEN)
    else $error("second key did not unlock");
  a_second_key: assert property (
    key_wr && st_r.lock == fwg_pkg::FWG_FIRST &&
    sfr_wdata != `FWG_KEY_SECOND |=> st_r.lock == fwg_pkg::FWG_DEAD)
    else $error("bad second key did not disable");
  a_open_rekey: assert property (
    key_wr && st_r.lock == fwg_pkg::FWG_OPEN |=>
    st_r.lock == fwg_pkg::FWG_DEAD)
    else $error("key write while open did not disable");
  a_dead_stays: assert property (
    st_r.lock == fwg_pkg::FWG_DEAD |=> st_r.lock == fwg_pkg::FWG_DEAD)
    else $error("disabled state left without reset");

  // ==========================================================
  // Operation checks
  // A move during a running operation keeps it going, so only an
  // idle gate must show a clean refusal
  a_locked_write: assert property (
    flash_wr && !key_wr && !busy && st_r.lock != fwg_pkg::FWG_OPEN |=>
    !flash_prog && !flash_erase && flash_blocked)
    else $error("write passed while locked");
  a_busy_write: assert property (
    flash_wr && !key_wr && busy |=>
    flash_blocked && st_r.lock == fwg_pkg::FWG_DEAD)
    else $error("second move during operation not refused");
  a_write_prog: assert property (
    flash_wr && !key_wr && st_r.lock == fwg_pkg::FWG_OPEN && !busy &&
    !st_r.erase_en |=> flash_prog && flash_data == $past(xdata_wdata))
    else $error("byte write not started");
  a_erase_go: assert property (
    flash_wr && !key_wr && st_r.lock == fwg_pkg::FWG_OPEN && !busy &&
    st_r.erase_en |=> flash_erase && !flash_prog)
    else $error("page erase not started");
  a_erase_data: assert property (
    flash_wr && !key_wr && st_r.lock == fwg_pkg::FWG_OPEN && !busy &&
    st_r.erase_en |=>
    flash_data == 8'hff && flash_addr == $past(xdata_addr))
    else $error("page erase did not ignore the data byte");
  a_one_kind: assert property (
    !(flash_prog && flash_erase))
    else $error("program and erase at once");
  a_op_hold: assert property (
    busy && !flash_done |=> busy)
    else $error("operation dropped before done");
  a_op_end: assert property (
    busy && flash_done |=> !busy)
    else $error("operation kept after done");
  a_relock: assert property (
    busy && flash_done && !key_wr && !flash_wr &&
    st_r.lock == fwg_pkg::FWG_OPEN |=> st_r.lock == fwg_pkg::FWG_LOCKED)
    else $error("no relock after operation");
  a_no_enable: assert property (
    xdata_wr && !st_r.write_en |=> !$rose(flash_prog|flash_erase))
    else $error("flash op without write enable");
  a_one_op: assert property (
    $rose(busy) |-> st_r.lock == fwg_pkg::FWG_OPEN)
    else $error("operation started while not open");

  // ==========================================================
  // Read checks
  a_ctrl_read: assert property (
    ctrl_rd |=> sfr_rdata[7:2] == 6'h00)
    else $error("control upper bits not zero");
  a_ctrl_value: assert property (
    ctrl_rd |=> sfr_rdata[1:0] == {st_r.erase_en, st_r.write_en})
    else $error("control read not enable bits");
  a_key_read: assert property (
    key_rd |=> sfr_rdata[1:0] == st_r.lock && sfr_rdata[7:2] == 6'h00)
    else $error("key read not lock state");
  a_rdata_idle: assert property (
    !sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero without a read");

  // ==========================================================
  // Coverage
  c_unlock: cover property (
    st_r.lock == fwg_pkg::FWG_FIRST ##1 st_r.lock == fwg_pkg::FWG_OPEN);
  c_write: cover property (
    $rose(flash_prog));
  c_erase: cover property (
    $rose(flash_erase));
  c_dead: cover property (
    $rose(st_r.lock == fwg_pkg::FWG_DEAD));
  c_relock: cover property (
    st_r.lock == fwg_pkg::FWG_OPEN && busy ##1
    st_r.lock == fwg_pkg::FWG_LOCKED);

endmodule
`default_nettype wire

// >>> sim/fwg_flash_model.sv
/*
 Flash array stand-in: answers each started program or erase with one
 flash_done pulse after dly+1 busy cycles.
 Assumes the gate holds flash_prog or flash_erase until it sees done.
*/
`timescale 1ns/1ps
`default_nettype none
module fwg_flash_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       flash_prog,
  input  wire logic       flash_erase,
  input  wire logic [7:0] dly,
  output logic            flash_done
);
  logic [7:0] cnt;
  // ==========================
  // Completion
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 8'h00;
      flash_done <= 1'b0;
    end else if (flash_prog | flash_erase) begin
      cnt <= cnt + 8'h01;
      flash_done <= (cnt == dly);
    end else begin
      cnt <= 8'h00;
      flash_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb.sv
/*
 Self-checking bench for the flash write and erase gate.
 Assumes the gate, its header and the flash model are compiled first.
*/
`timescale 1ns/1ps
`include "fwg_defs.svh"
`default_nettype none
module tb;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0, xdata_wr = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, xdata_wdata = 8'h00;
  logic [15:0] xdata_addr = 16'h0000, flash_addr;
  logic [7:0]  sfr_rdata, flash_data, dly = 8'h00;
  logic        flash_done, flash_prog, flash_erase;
  logic        flash_blocked, flash_route;
  int          error_cnt = 0, check_count = 0, cycles = 0;
  fwg_gate u_fwg_gate (.clk(clk), .sys_rst(sys_rst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
    .xdata_wdata(xdata_wdata), .flash_done(flash_done),
    .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_data(flash_data),
    .flash_blocked(flash_blocked), .flash_route(flash_route));
  fwg_flash_model u_fwg_flash_model (.clk(clk), .sys_rst(sys_rst),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .dly(dly),
    .flash_done(flash_done));
  // ==========================
  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  // ==========================
  // Access tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    chk(sfr_rdata, exp);
  endtask
  // Returns in the cycle where the gate's answer stands
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    xdata_addr <= a;
    xdata_wdata <= d;
    xdata_wr <= 1'b1;
    @(posedge clk);
    xdata_wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic unlock();
    wr(`FWG_KEY_ADDR, `FWG_KEY_FIRST);
    wr(`FWG_KEY_ADDR, `FWG_KEY_SECOND);
  endtask
  task automatic idle();
    for (int i = 0; i < 100 && (flash_prog | flash_erase) !== 1'b0; i++)
      @(negedge clk);
    chk(flash_prog | flash_erase, 1'b0);
  endtask
  task automatic rs();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================
  // Sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`FWG_CTRL_ADDR, 8'h00);
    rd(`FWG_KEY_ADDR, 8'h00);
    rd(8'h20, 8'h00);
    wr(`FWG_CTRL_ADDR, 8'hff);
    rd(`FWG_CTRL_ADDR, 8'h03);
    // Slow erase of the page before programming into it
    dly <= 8'h28;
    wr(`FWG_KEY_ADDR, `FWG_KEY_FIRST);
    rd(`FWG_KEY_ADDR, 8'h01);
    wr(`FWG_KEY_ADDR, `FWG_KEY_SECOND);
    rd(`FWG_KEY_ADDR, 8'h02);
    xw(16'h0234, 8'h77);
    chk({flash_erase, flash_prog, flash_data}, 16'h02ff);
    chk(flash_addr, 16'h0234);
    idle();
    rd(`FWG_KEY_ADDR, 8'h00);
    dly <= 8'h00;
    unlock();
    wr(`FWG_CTRL_ADDR, 8'h01);
    xw(16'h0234, 8'h5a);
    chk({flash_prog, flash_erase, flash_route, flash_data}, 16'h055a);
    chk(flash_addr, 16'h0234);
    idle();
    // Second move after one operation is refused
    xw(16'h0235, 8'h11);
    chk({flash_blocked, flash_prog}, 16'h0002);
    rd(`FWG_KEY_ADDR, 8'h03);
    unlock();
    rd(`FWG_KEY_ADDR, 8'h03);
    rs();
    rd(`FWG_KEY_ADDR, 8'h00);
    rd(`FWG_CTRL_ADDR, 8'h00);
    xw(16'h0300, 8'h22);
    chk({flash_blocked, flash_prog, flash_route}, 16'h0000);
    rd(`FWG_KEY_ADDR, 8'h00);
    wr(`FWG_KEY_ADDR, `FWG_KEY_FIRST);
    wr(`FWG_KEY_ADDR, 8'h00);
    rd(`FWG_KEY_ADDR, 8'h03);
    rs();
    wr(`FWG_KEY_ADDR, 8'h5a);
    rd(`FWG_KEY_ADDR, 8'h03);
    // Second move while the first is still busy
    rs();
    dly <= 8'h0a;
    wr(`FWG_CTRL_ADDR, 8'h01);
    unlock();
    xw(16'h0400, 8'h33);
    xw(16'h0401, 8'h44);
    chk({flash_blocked, flash_prog, flash_data}, 16'h0333);
    rd(`FWG_KEY_ADDR, 8'h03);
    idle();
    rd(`FWG_KEY_ADDR, 8'h03);
    // Key write while already open
    rs();
    unlock();
    wr(`FWG_KEY_ADDR, `FWG_KEY_FIRST);
    rd(`FWG_KEY_ADDR, 8'h03);
    close_out();
  end
endmodule
`default_nettype wire
